/* src/ocd_decoder.sv */
/*
 Opcode subset decoder and sequencer: takes an opcode from the fetch unit,
 decodes it, holds busy for one cycle less than the execution cycle count, then done, and emits datapath
 strobes plus the OR/multiply/LOAD_EFFECTIVE_ADDRESS/POP results. Assumes fetch unit and
 register file share sys_clk; opcodes outside the subset are passed on.
*/
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Opcode 84 loads working register from extended address; 3 bytes, 2 cycles, no flags.
// - Opcodes 98/99 compute register or pair plus displacement; 3 and 5 cycles, 3 bytes.
// - Opcode F4 multiplies pair high by low byte into pair; 2 bytes, 8 cycles.
// - Opcode 0F is a one-byte no-operation of 2 cycles, touching nothing.
// - Opcodes 42-47 OR into destination; Z,S follow result, V cleared, others kept.
// - Opcodes 48/49 OR on extended addresses; 4 bytes, 3 cycles, same flags.
module ocd_decoder (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clkEn,
    // Fetch side
    input wire logic opValid,
    input wire logic [7:0] opcode,
    output logic opReady,
    // Operands from register file
    input wire logic [7:0] dstData,
    input wire logic [7:0] srcData,
    input wire logic [15:0] pairData,
    input wire logic [7:0] displacement,
    input wire logic [7:0] stackByte,
    input wire logic [7:0] stackPtr,
    // Decode and results
    output ocd_pkg::ocd_decode_type decodeOut,
    output logic busy,
    output logic done,
    output ocd_pkg::ocd_strobe_type strobes,
    output logic [15:0] result,
    output logic [7:0] stackPtrNext,
    output logic flagZero,
    output logic flagSign,
    // Pass-through for opcodes not handled here
    output logic passValid,
    output logic [7:0] passOpcode
);

    typedef enum logic [1:0] {
        ST_IDLE, ST_EXEC, ST_DONE
    } ocd_state_type;

    typedef struct packed {
        ocd_state_type state;
        ocd_pkg::ocd_decode_type dec;
        logic [3:0] count;
        logic [15:0] res;
        logic [7:0] sp;
        logic zero;
        logic sign;
        logic passValid;
        logic [7:0] passOp;
    } ocd_regs_type;

    ocd_regs_type state_r;
    ocd_regs_type state_nxt;
    ocd_pkg::ocd_decode_type tableOut;
    logic [7:0] orValue;
    logic [15:0] leaSum;

    ocd_table u_table (
        .opcode(opcode),
        .decode(tableOut)
    );

    // Arithmetic sources; sign-extended displacement for the pair address form
    assign orValue = dstData | srcData;
    assign leaSum = pairData + {{8{displacement[7]}}, displacement};

    // Next-state and result capture
    always_comb begin
        state_nxt = state_r;
        state_nxt.passValid = 1'b0;
        unique case (state_r.state)
            ST_IDLE: begin
                if (opValid) begin
                    if (tableOut.hit) begin
                        state_nxt.dec = tableOut;
                        state_nxt.count = tableOut.execCycles - 4'h1;
                        state_nxt.state = ST_EXEC;
                    end else begin
                        state_nxt.passValid = 1'b1;
                        state_nxt.passOp = opcode;
                    end
                end
            end
            ST_EXEC: begin
                // Result latched on the last execution cycle
                if (state_r.count == 4'h1) begin
                    state_nxt.state = ST_DONE;
                    unique case (state_r.dec.opClass)
                        ocd_pkg::OPC_OR: begin
                            state_nxt.res = {8'h00, orValue};
                            state_nxt.zero = (orValue == 8'h00);
                            state_nxt.sign = orValue[7];
                        end
                        ocd_pkg::OPC_MULTIPLY: begin
                            state_nxt.res = pairData[15:8] * pairData[7:0];
                        end
                        ocd_pkg::OPC_LEA: begin
                            state_nxt.res = (state_r.dec.opcode == ocd_pkg::OP_LEA_REG) ?
                                {8'h00, dstData + displacement} : leaSum;
                        end
                        ocd_pkg::OPC_POP: begin
                            state_nxt.res = {8'h00, stackByte};
                            state_nxt.sp = stackPtr + 8'h01;
                        end
                        ocd_pkg::OPC_LOAD_EXT: begin
                            state_nxt.res = {8'h00, srcData};
                        end
                        default: begin
                            state_nxt.res = state_r.res;
                        end
                    endcase
                end else begin
                    state_nxt.count = state_r.count - 4'h1;
                end
                // Single-cycle instructions never occur, but guard count 0
                if (state_r.count == 4'h0) begin
                    state_nxt.state = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt.state = ST_IDLE;
            end
        endcase
    end

    // State register; clock enable freezes everything
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= '0;
            state_r.state <= ST_IDLE;
            state_r.count <= ocd_pkg::RESET_COUNT;
            state_r.passOp <= ocd_pkg::RESET_OPCODE;
        end else if (clkEn) begin
            state_r <= state_nxt;
        end
    end

    // Handshake is combinational; accepted only when idle
    assign opReady = (state_r.state == ST_IDLE);
    assign busy = (state_r.state == ST_EXEC);
    assign done = (state_r.state == ST_DONE);
    assign decodeOut = state_r.dec;
    assign result = state_r.res;
    assign stackPtrNext = state_r.sp;
    assign passValid = state_r.passValid;
    assign passOpcode = state_r.passOp;

    // Flags only meaningful for OR; other classes leave them alone
    assign flagZero = state_r.zero;
    assign flagSign = state_r.sign;

    // Strobes only on the done cycle, so the datapath writes once
    always_comb begin
        strobes = '0;
        if (state_r.state == ST_DONE) begin
            strobes.orEnable = (state_r.dec.opClass == ocd_pkg::OPC_OR);
            strobes.multiplyEnable = (state_r.dec.opClass == ocd_pkg::OPC_MULTIPLY);
            strobes.leaEnable = (state_r.dec.opClass == ocd_pkg::OPC_LEA);
            strobes.loadEnable = (state_r.dec.opClass == ocd_pkg::OPC_LOAD_EXT);
            strobes.popEnable = (state_r.dec.opClass == ocd_pkg::OPC_POP);
            strobes.spIncrement = state_r.dec.spIncrement;
            strobes.dstWrite = state_r.dec.writesDst;
        end
    end

endmodule

`default_nettype wire

/* src/ocd_pkg.sv */
/*
 Package for the opcode subset decoder: opcode values, fetch lengths,
 execution cycle counts, addressing modes and flag effect encodings.
 Assumes a single system clock domain; nothing here is clocked.
*/
package ocd_pkg;

    // Opcodes handled by this slice
    localparam logic [7:0] OP_LOAD_EXT = 8'h84;
    localparam logic [7:0] OP_LEA_REG = 8'h98;
    localparam logic [7:0] OP_LEA_PAIR = 8'h99;
    localparam logic [7:0] OP_MULTIPLY = 8'hf4;
    localparam logic [7:0] OP_NOP = 8'h0f;
    localparam logic [7:0] OP_OR_RR = 8'h42;
    localparam logic [7:0] OP_OR_RIR = 8'h43;
    localparam logic [7:0] OP_OR_R_R = 8'h44;
    localparam logic [7:0] OP_OR_R_IR = 8'h45;
    localparam logic [7:0] OP_OR_R_IM = 8'h46;
    localparam logic [7:0] OP_OR_IR_IM = 8'h47;
    localparam logic [7:0] OP_OR_EXT_EXT = 8'h48;
    localparam logic [7:0] OP_OR_EXT_IM = 8'h49;
    localparam logic [7:0] OP_POP_DIR = 8'h50;
    localparam logic [7:0] OP_POP_IND = 8'h51;

    // Fetch lengths in bytes
    localparam logic [2:0] FETCH_1 = 3'h1;
    localparam logic [2:0] FETCH_2 = 3'h2;
    localparam logic [2:0] FETCH_3 = 3'h3;
    localparam logic [2:0] FETCH_4 = 3'h4;

    // Execution cycle counts
    localparam logic [3:0] EXEC_2 = 4'h2;
    localparam logic [3:0] EXEC_3 = 4'h3;
    localparam logic [3:0] EXEC_4 = 4'h4;
    localparam logic [3:0] EXEC_5 = 4'h5;
    localparam logic [3:0] EXEC_8 = 4'h8;

    // Reset values
    localparam logic [7:0] RESET_OPCODE = 8'h00;
    localparam logic [3:0] RESET_COUNT = 4'h0;

    // Operand addressing modes
    typedef enum logic [3:0] {
        AM_NONE, AM_WREG, AM_IND_WREG, AM_REG, AM_IND_REG, AM_IMM,
        AM_EXT_ADDR, AM_PAIR, AM_IND_PAIR, AM_INDEXED_REG, AM_INDEXED_PAIR
    } ocd_mode_type;

    // Operation classes
    typedef enum logic [2:0] {
        OPC_PASS, OPC_LOAD_EXT, OPC_LEA, OPC_MULTIPLY, OPC_NOP, OPC_OR, OPC_POP
    } ocd_class_type;

    // Per-flag effect
    typedef enum logic [1:0] {
        FX_KEEP, FX_RESULT, FX_CLEAR
    } ocd_effect_type;

    // Flag effect set: carry, zero, sign, overflow, decimal, half-carry
    typedef struct packed {
        ocd_effect_type carry;
        ocd_effect_type zero;
        ocd_effect_type sign;
        ocd_effect_type overflow;
        ocd_effect_type decimal;
        ocd_effect_type halfCarry;
    } ocd_flags_type;

    // Decoded instruction descriptor
    typedef struct packed {
        logic hit;
        logic [7:0] opcode;
        ocd_class_type opClass;
        ocd_mode_type dstMode;
        ocd_mode_type srcMode;
        logic [2:0] fetchBytes;
        logic [3:0] execCycles;
        ocd_flags_type flags;
        logic writesDst;
        logic spIncrement;
    } ocd_decode_type;

    // Datapath strobe group
    typedef struct packed {
        logic orEnable;
        logic multiplyEnable;
        logic leaEnable;
        logic loadEnable;
        logic popEnable;
        logic spIncrement;
        logic dstWrite;
    } ocd_strobe_type;

endpackage

/* src/ocd_table.sv */
/*
 Combinational opcode table for the decoder slice.
 Assumes the opcode byte is already stable on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none

module ocd_table (
    // Opcode in
    input wire logic [7:0] opcode,
    // Descriptor out
    output ocd_pkg::ocd_decode_type decode
);

    // Lookup; miss leaves every side effect low
    always_comb begin
        decode = '0;
        decode.opcode = opcode;
        decode.opClass = ocd_pkg::OPC_PASS;
        decode.dstMode = ocd_pkg::AM_NONE;
        decode.srcMode = ocd_pkg::AM_NONE;
        decode.flags = '{default: ocd_pkg::FX_KEEP};
        unique case (opcode)
            ocd_pkg::OP_LOAD_EXT: begin
                decode.hit = 1'b1;
                decode.opClass = ocd_pkg::OPC_LOAD_EXT;
                decode.dstMode = ocd_pkg::AM_WREG;
                decode.srcMode = ocd_pkg::AM_EXT_ADDR;
                decode.fetchBytes = ocd_pkg::FETCH_3;
                decode.execCycles = ocd_pkg::EXEC_2;
                decode.writesDst = 1'b1;
            end
            ocd_pkg::OP_LEA_REG, ocd_pkg::OP_LEA_PAIR: begin
                decode.hit = 1'b1;
                decode.opClass = ocd_pkg::OPC_LEA;
                decode.fetchBytes = ocd_pkg::FETCH_3;
                decode.writesDst = 1'b1;
                if (opcode == ocd_pkg::OP_LEA_REG) begin
                    decode.dstMode = ocd_pkg::AM_WREG;
                    decode.srcMode = ocd_pkg::AM_INDEXED_REG;
                    decode.execCycles = ocd_pkg::EXEC_3;
                end else begin
                    decode.dstMode = ocd_pkg::AM_PAIR;
                    decode.srcMode = ocd_pkg::AM_INDEXED_PAIR;
                    decode.execCycles = ocd_pkg::EXEC_5;
                end
            end
            ocd_pkg::OP_MULTIPLY: begin
                decode.hit = 1'b1;
                decode.opClass = ocd_pkg::OPC_MULTIPLY;
                decode.dstMode = ocd_pkg::AM_PAIR;
                decode.fetchBytes = ocd_pkg::FETCH_2;
                decode.execCycles = ocd_pkg::EXEC_8;
                decode.writesDst = 1'b1;
            end
            ocd_pkg::OP_NOP: begin
                decode.hit = 1'b1;
                decode.opClass = ocd_pkg::OPC_NOP;
                decode.fetchBytes = ocd_pkg::FETCH_1;
                decode.execCycles = ocd_pkg::EXEC_2;
            end
            ocd_pkg::OP_OR_RR, ocd_pkg::OP_OR_RIR, ocd_pkg::OP_OR_R_R,
            ocd_pkg::OP_OR_R_IR, ocd_pkg::OP_OR_R_IM, ocd_pkg::OP_OR_IR_IM,
            ocd_pkg::OP_OR_EXT_EXT, ocd_pkg::OP_OR_EXT_IM: begin
                decode.hit = 1'b1;
                decode.opClass = ocd_pkg::OPC_OR;
                decode.writesDst = 1'b1;
                decode.flags.zero = ocd_pkg::FX_RESULT;
                decode.flags.sign = ocd_pkg::FX_RESULT;
                decode.flags.overflow = ocd_pkg::FX_CLEAR;
                decode.execCycles = ocd_pkg::EXEC_3;
                decode.fetchBytes = ocd_pkg::FETCH_3;
                unique case (opcode)
                    ocd_pkg::OP_OR_RR: begin
                        decode.dstMode = ocd_pkg::AM_WREG;
                        decode.srcMode = ocd_pkg::AM_WREG;
                        decode.fetchBytes = ocd_pkg::FETCH_2;
                    end
                    ocd_pkg::OP_OR_RIR: begin
                        decode.dstMode = ocd_pkg::AM_WREG;
                        decode.srcMode = ocd_pkg::AM_IND_WREG;
                        decode.fetchBytes = ocd_pkg::FETCH_2;
                        decode.execCycles = ocd_pkg::EXEC_4;
                    end
                    ocd_pkg::OP_OR_R_R: begin
                        decode.dstMode = ocd_pkg::AM_REG;
                        decode.srcMode = ocd_pkg::AM_REG;
                    end
                    ocd_pkg::OP_OR_R_IR: begin
                        decode.dstMode = ocd_pkg::AM_REG;
                        decode.srcMode = ocd_pkg::AM_IND_REG;
                        decode.execCycles = ocd_pkg::EXEC_4;
                    end
                    ocd_pkg::OP_OR_R_IM: begin
                        decode.dstMode = ocd_pkg::AM_REG;
                        decode.srcMode = ocd_pkg::AM_IMM;
                    end
                    ocd_pkg::OP_OR_IR_IM: begin
                        decode.dstMode = ocd_pkg::AM_IND_REG;
                        decode.srcMode = ocd_pkg::AM_IMM;
                        decode.execCycles = ocd_pkg::EXEC_4;
                    end
                    ocd_pkg::OP_OR_EXT_EXT: begin
                        decode.dstMode = ocd_pkg::AM_EXT_ADDR;
                        decode.srcMode = ocd_pkg::AM_EXT_ADDR;
                        decode.fetchBytes = ocd_pkg::FETCH_4;
                    end
                    default: begin
                        decode.dstMode = ocd_pkg::AM_EXT_ADDR;
                        decode.srcMode = ocd_pkg::AM_IMM;
                        decode.fetchBytes = ocd_pkg::FETCH_4;
                    end
                endcase
            end
            ocd_pkg::OP_POP_DIR, ocd_pkg::OP_POP_IND: begin
                decode.hit = 1'b1;
                decode.opClass = ocd_pkg::OPC_POP;
                decode.fetchBytes = ocd_pkg::FETCH_2;
                decode.writesDst = 1'b1;
                decode.spIncrement = 1'b1;
                decode.dstMode = (opcode == ocd_pkg::OP_POP_DIR) ?
                    ocd_pkg::AM_REG : ocd_pkg::AM_IND_REG;
                decode.execCycles = (opcode == ocd_pkg::OP_POP_DIR) ?
                    ocd_pkg::EXEC_2 : ocd_pkg::EXEC_3;
            end
            default: begin
                decode.hit = 1'b0;
            end
        endcase
    end

endmodule

`default_nettype wire

/* test/cpu_opcode_subset_decode_bench.sv */
/*
 Self-checking bench for the opcode subset decoder.
 Assumes the fetch model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`default_nettype none

module cpu_opcode_subset_decode_bench;
    logic sys_clk, rst, clkEn, opValid, opReady, busy, done;
    logic flagZero, flagSign, passValid;
    logic [7:0] opcode, dstData, srcData, displacement, stackByte;
    logic [7:0] stackPtr, stackPtrNext, passOpcode;
    logic [15:0] pairData, result;
    ocd_pkg::ocd_decode_type decodeOut;
    ocd_pkg::ocd_strobe_type strobes;
    int err_count = 0;
    int cmp_count = 0;

    ocd_decoder DUT (.sys_clk, .rst, .clkEn, .opValid, .opcode, .opReady, .dstData,
        .srcData, .pairData, .displacement, .stackByte, .stackPtr, .decodeOut, .busy,
        .done, .strobes, .result, .stackPtrNext, .flagZero, .flagSign, .passValid,
        .passOpcode);
    ocd_fetch_model FET (.sys_clk, .opReady, .opValid, .opcode);

    // 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Offer one opcode, count edges from accept to done (bounded)
    task automatic run(input logic [7:0] op, output int n);
        FET.offer(op, 0);
        n = 1; // Take edge is the first execution cycle
        while (done !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    // Every subset opcode: cycles, length, flag effects; entry is op,fetch,exec
    task automatic t_table();
        logic [15:0] tab [15] = '{16'h8432, 16'h9833, 16'h9935, 16'hf428, 16'h0f12,
            16'h4223, 16'h4324, 16'h4433, 16'h4534, 16'h4633, 16'h4734, 16'h4843,
            16'h4943, 16'h5022, 16'h5123};
        logic [11:0] fx;
        int n;
        foreach (tab[i]) begin
            fx = (tab[i][15:8] inside {[8'h42:8'h49]}) ? 12'h160 : 12'h000;
            run(tab[i][15:8], n);
            chk("exec cycles", {12'h000, tab[i][3:0]}, 16'(n));
            chk("fetch bytes", {12'h000, tab[i][7:4]}, {13'h0000, decodeOut.fetchBytes});
            chk("flag effects", {4'h0, fx}, {4'h0, decodeOut.flags});
        end
    endtask

    // Zero result then sign result
    task automatic t_or();
        int n;
        for (int i = 0; i < 2; i++) begin
            dstData = i ? 8'h80 : 8'h00;
            srcData = i ? 8'h01 : 8'h00;
            run(i ? ocd_pkg::OP_OR_R_R : ocd_pkg::OP_OR_RR, n);
            chk("or result", {8'h00, dstData | srcData}, {8'h00, result[7:0]});
            chk("zero flag", 16'(i == 0), {15'h0000, flagZero});
            chk("sign flag", 16'(i), {15'h0000, flagSign});
        end
    endtask

    // Idle opcode leaves result and flags alone
    task automatic t_nop();
        logic [15:0] keep;
        int n;
        keep = result;
        run(ocd_pkg::OP_NOP, n);
        chk("nop result", keep, result);
        chk("nop flags", 16'h0001, {14'h0000, flagZero, flagSign});
    endtask

    // Near-largest factors, FF by FE
    task automatic t_mul();
        int n;
        pairData = 16'hfffe;
        run(ocd_pkg::OP_MULTIPLY, n);
        chk("product", 16'hfd02, result);
    endtask

    // Displacement carries into the sign bit, then a negative displacement on the pair
    task automatic t_lea();
        int n;
        dstData = 8'h7f;
        displacement = 8'h01;
        run(ocd_pkg::OP_LEA_REG, n);
        chk("address sum", 16'h0080, {8'h00, result[7:0]});
        pairData = 16'h1000;
        displacement = 8'hff;
        run(ocd_pkg::OP_LEA_PAIR, n);
        chk("pair sum", 16'h0fff, result);
    endtask

    // Stack pointer wraps on increment
    task automatic t_pop();
        int n;
        stackPtr = 8'hff;
        stackByte = 8'h5a;
        run(ocd_pkg::OP_POP_IND, n);
        chk("stack pointer", 16'h0000, {8'h00, stackPtrNext});
        chk("pop byte", 16'h005a, result);
    endtask

    // Reset in mid-execution returns to idle with a cleared result
    task automatic t_reset();
        FET.offer(ocd_pkg::OP_MULTIPLY, 0);
        rst = 1'b1;
        @(posedge sys_clk);
        #1;
        rst = 1'b0;
        chk("reset busy", 16'h0000, {15'h0000, busy});
        chk("reset result", 16'h0000, result);
        chk("reset ready", 16'h0001, {15'h0000, opReady});
    endtask

    // Clock enable low freezes execution; the remaining cycles follow re-enable
    task automatic t_hold();
        FET.offer(ocd_pkg::OP_LEA_REG, 0);
        clkEn = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("frozen busy", 16'h0001, {15'h0000, busy});
        chk("frozen done", 16'h0000, {15'h0000, done});
        clkEn = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("resumed done", 16'h0001, {15'h0000, done});
    endtask

    // Foreign opcode, offered slowly, is passed on with no effect
    task automatic t_pass();
        logic [15:0] keep;
        keep = result;
        FET.offer(8'h85, 3);
        if (passValid !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        chk("pass valid", 16'h0001, {15'h0000, passValid});
        chk("pass opcode", 16'h0085, {8'h00, passOpcode});
        repeat (4) @(posedge sys_clk);
        #1;
        chk("pass result", keep, result);
    endtask

    // Reset, then scenarios in order
    initial begin
        rst = 1'b1;
        clkEn = 1'b1;
        {dstData, srcData, displacement, stackByte, stackPtr} = '0;
        pairData = 16'h0000;
        repeat (2) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        t_table();
        t_or();
        t_nop();
        t_mul();
        t_lea();
        t_pop();
        t_reset();
        t_hold();
        t_pass();
        stop_test();
    end

    // Hang guard at 2000 cycles, well beyond the roughly 120 cycles needed
    initial begin
        #100000;
        err_count++;
        stop_test();
    end
endmodule

`default_nettype wire

/* test/ocd_decoder_monitor.sv */
/*
 Checker for the opcode subset decoder, bound to its top module.
 Assumes one clock domain and clkEn held high while opcodes run.
*/
`timescale 1ns/10ps
`default_nettype none

module ocd_decoder_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Fetch side
    input wire logic clkEn,
    input wire logic opValid,
    input wire logic [7:0] opcode,
    input wire logic opReady,
    // Decode and results
    input wire ocd_pkg::ocd_decode_type decodeOut,
    input wire logic busy,
    input wire logic done,
    input wire ocd_pkg::ocd_strobe_type strobes,
    input wire logic passValid
);
    // Accept edge as seen by the decoder
    logic take;
    assign take = clkEn && opValid && opReady;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_load;
        take && opcode == ocd_pkg::OP_LOAD_EXT |-> ##2 done && decodeOut.fetchBytes == 3'h3;
    endproperty
    a_load: assert property (p_load) else $error("load timing or length wrong");
    property p_lea;
        take && opcode == ocd_pkg::OP_LEA_PAIR |=> busy [*4] ##1 done;
    endproperty
    a_lea: assert property (p_lea) else $error("pair address timing wrong");
    property p_mul;
        take && opcode == ocd_pkg::OP_MULTIPLY |-> ##8 done && strobes.multiplyEnable;
    endproperty
    a_mul: assert property (p_mul) else $error("multiply timing wrong");
    property p_nop;
        take && opcode == ocd_pkg::OP_NOP |-> ##2 done && !strobes.dstWrite;
    endproperty
    a_nop: assert property (p_nop) else $error("idle opcode wrong");
    property p_or;
        take && opcode == ocd_pkg::OP_OR_RR |=> busy [*2] ##1 done && strobes.orEnable;
    endproperty
    a_or: assert property (p_or) else $error("short or timing wrong");
    // Long form must report the cleared overflow and its four bytes
    property p_orx;
        done && decodeOut.opcode == ocd_pkg::OP_OR_EXT_EXT
            |-> decodeOut.flags.overflow == ocd_pkg::FX_CLEAR && decodeOut.fetchBytes == 3'h4;
    endproperty
    a_orx: assert property (p_orx) else $error("long or descriptor wrong");
    property p_pop;
        take && opcode == ocd_pkg::OP_POP_IND |-> ##3 done && strobes.popEnable
            && strobes.spIncrement;
    endproperty
    a_pop: assert property (p_pop) else $error("pop timing wrong");
    property p_pass;
        passValid |-> !busy && !done;
    endproperty
    a_pass: assert property (p_pass) else $error("foreign opcode had effect");
endmodule

bind ocd_decoder ocd_decoder_monitor u_monitor (.sys_clk, .rst, .clkEn, .opValid, .opcode,
    .opReady, .decodeOut, .busy, .done, .strobes, .passValid);

`default_nettype wire

/* test/ocd_fetch_model.sv */
/*
 Fetch unit model: offers opcode bytes to the decoder.
 Assumes the bench calls offer from a point just after a clock edge.
*/
`timescale 1ns/10ps
`default_nettype none

module ocd_fetch_model (
    // Clock
    input wire logic sys_clk,
    // Handshake
    input wire logic opReady,
    output logic opValid,
    output logic [7:0] opcode
);
    // Nothing offered at start
    initial begin
        opValid = 1'b0;
        opcode = 8'h00;
    end

    // Hold the byte until ready is seen at an edge; gap makes a slow fetch
    task automatic offer(input logic [7:0] op, input int gap);
        repeat (gap) @(posedge sys_clk);
        #1;
        opValid = 1'b1;
        opcode = op;
        while (opReady !== 1'b1) begin
            @(posedge sys_clk);
            #1;
        end
        @(posedge sys_clk);
        #1;
        opValid = 1'b0;
        opcode = ~op; // Stale byte must not look valid
    endtask
endmodule

`default_nettype wire
